// ==== src/pe_regs_pkg.sv ====
/*
 Package for the processing-element data register bank with timer and user flags.
 Holds register offsets, field widths, reset values and operation codes.
 Assumes every user of it refers to names as pe_regs_pkg::name.
*/
package pe_regs_pkg;
   // Widths and counts
   localparam int DATA_W = 40;
   localparam int WORD_W = 32;
   localparam int NUM_DATA = 16;
   localparam int IDX_W = 4;
   localparam int ADDR_W = 8;
   localparam int NUM_FLAGS = 4;
   localparam int IRQ_W = 1;
   // Offsets on the register port, word index
   localparam logic [7:0] OFS_DATA_BASE = 8'h00;
   localparam logic [7:0] OFS_DATA_HI_BASE = 8'h10;
   localparam logic [7:0] OFS_TCOUNT = 8'h20;
   localparam logic [7:0] OFS_TPERIOD = 8'h21;
   localparam logic [7:0] OFS_FLAGS_BASE = 8'h24;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h29;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h2a;
   localparam logic [7:0] OFS_TIMER_CTRL = 8'h2b;
   // Field positions
   localparam int TIMER_EN_BIT = 0;
   localparam int IRQ_TIMER_BIT = 0;
   localparam int HI_W = DATA_W - WORD_W;
   // Reset values and count step
   localparam logic [39:0] DATA_RST = 40'h00_0000_0000;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [31:0] ONE_WORD = 32'h0000_0001;
   // Flag operation codes
   typedef enum logic [1:0] {
      FLAG_WRITE,
      FLAG_SET,
      FLAG_CLEAR,
      FLAG_TOGGLE
   } flag_op_t;
   // Data transfer width from the bus, independent of register view
   typedef enum logic {
      XFER_32,
      XFER_40
   } xfer_w_t;
endpackage

// ==== src/pe_unit_if.sv ====
/*
 Interface between the bank top and its timer and flag submodules.
 Assumes all parties run on ref_clk.
*/
`timescale 1ns/1ns
interface pe_unit_if;
   logic [31:0] wdata; // Write data for the selected unit
   logic tcount_we; // Load the countdown value
   logic tperiod_we; // Load the reload period
   logic timer_en; // Count enable
   logic [31:0] tcount; // Current count
   logic [31:0] tperiod; // Current period
   logic expire; // One-cycle pulse on count reaching zero
   logic [3:0] flag_we; // Per flag word write
   pe_regs_pkg::flag_op_t flag_op; // Operation for flag writes
   logic [31:0] flag_word [4]; // Flag contents
   logic [31:0] test_mask; // Bit mask for a test
   logic [1:0] test_sel; // Flag word to test
   logic test_hit; // Any masked bit set

   modport top (output wdata, tcount_we, tperiod_we, timer_en, flag_we, flag_op, test_mask, test_sel,
                input tcount, tperiod, expire, flag_word, test_hit);
   modport timer (input wdata, tcount_we, tperiod_we, timer_en, output tcount, tperiod, expire);
   modport flags (input wdata, flag_we, flag_op, test_mask, test_sel, output flag_word, test_hit);
endinterface

// ==== src/pe_timer.sv ====
/*
 Down-counting timer with reload period.
 Assumes a single clock and software writes arriving as one-cycle strobes.
*/
`timescale 1ns/1ns
module pe_timer (
   input wire logic ref_clk,
   input wire logic rst_b,
   pe_unit_if.timer u
);
   logic [31:0] count_ff;
   logic [31:0] period_ff;
   logic expire_ff;
   logic [31:0] nxt_count;
   wire at_zero = (count_ff == pe_regs_pkg::WORD_RST); // Count exhausted
   wire fire = u.timer_en && at_zero && !u.tcount_we; // Expiry event

   // A software write wins over counting; at zero reload from period
   assign nxt_count = u.tcount_we ? u.wdata :
                      !u.timer_en ? count_ff :
                      at_zero ? period_ff : // [RL11]
                      count_ff - pe_regs_pkg::ONE_WORD; // [RL7]
   assign u.tcount = count_ff;
   assign u.tperiod = period_ff;
   assign u.expire = expire_ff;

   // Count and period storage
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         count_ff <= pe_regs_pkg::WORD_RST;
         period_ff <= pe_regs_pkg::WORD_RST;
         expire_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         if (u.tperiod_we) begin
            period_ff <= u.wdata; // [RL8]
         end
         expire_ff <= fire; // [RL11]
      end
   end
endmodule

// ==== src/pe_user_flags.sv ====
/*
 Four general purpose 32-bit flag words with bitwise set, clear, toggle, test.
 Assumes one write per cycle from the bank top.
*/
`timescale 1ns/1ns
module pe_user_flags (
   input wire logic ref_clk,
   input wire logic rst_b,
   pe_unit_if.flags u
);
   // Bitwise update; only masked bits move on set, clear and toggle
   function automatic logic [31:0] apply_op(input logic [31:0] old, input logic [31:0] m,
                                            input pe_regs_pkg::flag_op_t op);
      case (op)
         pe_regs_pkg::FLAG_SET: apply_op = old | m; // [RL12]
         pe_regs_pkg::FLAG_CLEAR: apply_op = old & ~m; // [RL12]
         pe_regs_pkg::FLAG_TOGGLE: apply_op = old ^ m;
         default: apply_op = m; // Full word store [RL10]
      endcase
   endfunction

   logic [31:0] word_ff [4];
   genvar g;
   generate
      for (g = 0; g < pe_regs_pkg::NUM_FLAGS; g++) begin : g_word
         // No hardware meaning: only software moves these bits
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               word_ff[g] <= pe_regs_pkg::WORD_RST;
            end else if (u.flag_we[g]) begin
               word_ff[g] <= apply_op(word_ff[g], u.wdata, u.flag_op); // [RL9]
            end
         end
         assign u.flag_word[g] = word_ff[g];
      end
   endgenerate
   // Test: any selected bit set
   assign u.test_hit = |(word_ff[u.test_sel] & u.test_mask); // [RL9]
endmodule

// ==== src/pe_data_regs_timer_ustat.sv ====
/*
 Register bank of one processing element: sixteen 40-bit data registers, timer
 count and period, four user flag words, and a timer interrupt.
 Assumes: ref_clk at 100 MHz, rst_b asynchronous active low, one compute write
 port and two compute read ports driven by the core, and a software register
 port with one-cycle strobes and read data one cycle later.
*/
// Functional notes
// [RL1] Own file of sixteen 40-bit registers
// [RL2] Registers link buses and compute units
// [RL3] Fixed and float names share storage
// [RL4] View choice never changes transfer width
// [RL5] View steers unit interpretation and element
// [RL6] Each register holds bits 39 to 0
// [RL7] Count decrements once per cycle
// [RL8] Period sets cycles between interrupts
// [RL9] Flag words support set, clear, test; the bank top ties flag_op to FLAG_WRITE, so software only stores whole words
// [RL10] Flag words have no hardware meaning
// [RL11] At zero: interrupt and reload period
// [RL12] Set or clear touches selected bits
`timescale 1ns/1ns
module pe_data_regs_timer_ustat (
   input wire logic ref_clk,
   input wire logic rst_b,
   // Software register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Compute write port (results, bus loads)
   input wire logic cu_we,
   input wire logic [3:0] cu_widx,
   input wire logic [39:0] cu_wdata,
   input wire logic cu_wide,
   // Compute read ports with view selection
   input wire logic [3:0] cu_ridx_a,
   input wire logic [3:0] cu_ridx_b,
   input wire logic float_view_prefix,
   input wire logic secondary_element,
   output logic [39:0] cu_rdata_a,
   output logic [39:0] cu_rdata_b,
   output logic cu_float_mode,
   output logic cu_sel_element,
   // Bit test of a flag word
   input wire logic [1:0] test_sel,
   input wire logic [31:0] test_mask,
   output logic test_hit,
   // Interrupt
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   // Storage and shared interface
   logic [39:0] data_ff [16]; // One array, both views index it
   logic [31:0] rdata_ff;
   logic [39:0] rda_ff;
   logic [39:0] rdb_ff;
   logic float_ff;
   logic elem_ff;
   logic hit_ff;
   logic irq_ff;
   logic [0:0] irq_stat_ff; // Sticky event bits
   logic [0:0] irq_en_ff; // Interrupt enable
   logic timer_en_ff; // Timer run control
   pe_unit_if u ();

   pe_timer timer_i (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .u(u.timer)
   );
   pe_user_flags flags_i (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .u(u.flags)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Address decoding
   function automatic logic in_range(input logic [7:0] a, input logic [7:0] base);
      in_range = (a >= base) && (a < base + 8'(pe_regs_pkg::NUM_DATA));
   endfunction

   wire hit_lo = in_range(reg_addr, pe_regs_pkg::OFS_DATA_BASE);
   wire hit_hi = in_range(reg_addr, pe_regs_pkg::OFS_DATA_HI_BASE);
   wire [3:0] sw_idx = reg_addr[3:0]; // Both data windows are 16-aligned
   wire hit_flags = (reg_addr >= pe_regs_pkg::OFS_FLAGS_BASE) &&
                    (reg_addr < pe_regs_pkg::OFS_FLAGS_BASE + 8'(pe_regs_pkg::NUM_FLAGS));
   wire [1:0] flag_idx = 2'(reg_addr - pe_regs_pkg::OFS_FLAGS_BASE);
   wire [39:0] sel_data = data_ff[sw_idx];

   // Flag writes: plain store via register port
   assign u.wdata = reg_wdata;
   assign u.tcount_we = reg_wr && (reg_addr == pe_regs_pkg::OFS_TCOUNT);
   assign u.tperiod_we = reg_wr && (reg_addr == pe_regs_pkg::OFS_TPERIOD);
   assign u.timer_en = timer_en_ff;
   assign u.flag_op = pe_regs_pkg::FLAG_WRITE;
   assign u.test_mask = test_mask;
   assign u.test_sel = test_sel;
   genvar g;
   generate
      for (g = 0; g < pe_regs_pkg::NUM_FLAGS; g++) begin : g_fwe
         assign u.flag_we[g] = reg_wr && hit_flags && (flag_idx == 2'(g));
      end
   endgenerate

   // Read multiplexer; unmapped reads return zero
   logic [31:0] nxt_rdata;
   always_comb begin
      nxt_rdata = pe_regs_pkg::WORD_RST;
      if (hit_lo) begin
         nxt_rdata = sel_data[31:0];
      end else if (hit_hi) begin
         nxt_rdata = {24'h00_0000, sel_data[39:32]};
      end else if (reg_addr == pe_regs_pkg::OFS_TCOUNT) begin
         nxt_rdata = u.tcount; // [RL7]
      end else if (reg_addr == pe_regs_pkg::OFS_TPERIOD) begin
         nxt_rdata = u.tperiod; // [RL8]
      end else if (hit_flags) begin
         nxt_rdata = u.flag_word[flag_idx]; // [RL10]
      end else if (reg_addr == pe_regs_pkg::OFS_IRQ_STATUS) begin
         nxt_rdata = {31'h0000_0000, irq_stat_ff};
      end else if (reg_addr == pe_regs_pkg::OFS_IRQ_ENABLE) begin
         nxt_rdata = {31'h0000_0000, irq_en_ff};
      end else if (reg_addr == pe_regs_pkg::OFS_TIMER_CTRL) begin
         nxt_rdata = {31'h0000_0000, timer_en_ff};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data register array
   // Compute write has priority over software in the same cycle and index
   generate
      for (g = 0; g < pe_regs_pkg::NUM_DATA; g++) begin : g_data
         wire cu_hit = cu_we && (cu_widx == 4'(g));
         wire sw_lo = reg_wr && hit_lo && (sw_idx == 4'(g));
         wire sw_hi = reg_wr && hit_hi && (sw_idx == 4'(g));
         // 32-bit load fills bits 39:8, 40-bit load the whole word [RL4]
         wire [39:0] cu_val = cu_wide ? cu_wdata : {cu_wdata[31:0], 8'h00};
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               data_ff[g] <= pe_regs_pkg::DATA_RST;
            end else if (cu_hit) begin
               data_ff[g] <= cu_val; // [RL2] [RL6]
            end else if (sw_lo) begin
               data_ff[g][31:0] <= reg_wdata; // [RL6]
            end else if (sw_hi) begin
               data_ff[g][39:32] <= reg_wdata[7:0]; // [RL6]
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Compute reads: both views hit the same entry [RL3] [RL1]
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rda_ff <= pe_regs_pkg::DATA_RST;
         rdb_ff <= pe_regs_pkg::DATA_RST;
         float_ff <= 1'b0;
         elem_ff <= 1'b0;
         hit_ff <= 1'b0;
      end else begin
         rda_ff <= data_ff[cu_ridx_a]; // [RL2] [RL3]
         rdb_ff <= data_ff[cu_ridx_b]; // [RL3]
         float_ff <= float_view_prefix; // [RL5]
         elem_ff <= secondary_element; // [RL5]
         hit_ff <= u.test_hit; // [RL9]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control, interrupt and read data
   // Set from expiry wins over a clear in the same cycle
   wire [0:0] clr_mask = (reg_wr && reg_addr == pe_regs_pkg::OFS_IRQ_CLEAR) ? reg_wdata[0:0] : 1'b0;
   wire [0:0] nxt_stat = (irq_stat_ff & ~clr_mask) | u.expire; // [RL11]
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_stat_ff <= 1'b0;
         irq_en_ff <= 1'b0;
         timer_en_ff <= 1'b0;
         irq_ff <= 1'b0;
         rdata_ff <= pe_regs_pkg::WORD_RST;
      end else begin
         irq_stat_ff <= nxt_stat;
         if (reg_wr && reg_addr == pe_regs_pkg::OFS_IRQ_ENABLE) begin
            irq_en_ff <= reg_wdata[pe_regs_pkg::IRQ_TIMER_BIT];
         end
         if (reg_wr && reg_addr == pe_regs_pkg::OFS_TIMER_CTRL) begin
            timer_en_ff <= reg_wdata[pe_regs_pkg::TIMER_EN_BIT];
         end
         irq_ff <= |(nxt_stat & irq_en_ff); // [RL11]
         rdata_ff <= reg_rd ? nxt_rdata : pe_regs_pkg::WORD_RST;
      end
   end

   assign reg_rdata = rdata_ff;
   assign cu_rdata_a = rda_ff;
   assign cu_rdata_b = rdb_ff;
   assign cu_float_mode = float_ff;
   assign cu_sel_element = elem_ff;
   assign test_hit = hit_ff;
   assign irq = irq_ff;
endmodule

// ==== verification/pe_regs_properties.sv ====
/*
 Checker for the data register bank, watching only the top ports.
 Assumes the bench holds every input at zero while rst_b is low.
*/
`timescale 1ns/1ns
module pe_regs_checker (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic cu_we,
   input wire logic [3:0] cu_widx,
   input wire logic [39:0] cu_wdata,
   input wire logic cu_wide,
   input wire logic [3:0] cu_ridx_a,
   input wire logic [3:0] cu_ridx_b,
   input wire logic float_view_prefix,
   input wire logic secondary_element,
   input wire logic [39:0] cu_rdata_a,
   input wire logic [39:0] cu_rdata_b,
   input wire logic cu_float_mode,
   input wire logic cu_sel_element,
   input wire logic [1:0] test_sel,
   input wire logic [31:0] test_mask,
   input wire logic test_hit,
   input wire logic irq
);
   // One clock domain, one reset
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////
   // Read data only in the cycle after a read
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0000_0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
   // View outputs follow the view inputs one cycle later
   property p_view; cu_float_mode == $past(float_view_prefix) && cu_sel_element == $past(secondary_element); endproperty
   a_view: assert property (p_view) else $error("view copy wrong");
   // Wide load seen whole on port a
   property p_wide; (cu_we && cu_wide ##1 cu_ridx_a == $past(cu_widx)) |=> cu_rdata_a == $past(cu_wdata, 2); endproperty
   a_wide: assert property (p_wide) else $error("wide load lost");
   // Narrow load lands in bits 39:8, low byte zero
   property p_narrow;
      (cu_we && !cu_wide ##1 cu_ridx_b == $past(cu_widx)) |=> cu_rdata_b == {$past(cu_wdata[31:0], 2), 8'h00};
   endproperty
   a_narrow: assert property (p_narrow) else $error("narrow load wrong");
   // Dropping the enable drops the interrupt
   property p_irq_off; reg_wr && reg_addr == pe_regs_pkg::OFS_IRQ_ENABLE && !reg_wdata[0] |=> ##1 !irq; endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt not masked");
   // Bit test of flag word 0 right after it was written
   property p_hit;
      (reg_wr && reg_addr == pe_regs_pkg::OFS_FLAGS_BASE ##1 !reg_wr && test_sel == 2'h0 && test_mask == $past(reg_wdata))
      |=> test_hit == ($past(reg_wdata, 2) != 32'h0000_0000);
   endproperty
   a_hit: assert property (p_hit) else $error("bit test wrong");
   // Period reads back what was written
   property p_period;
      (reg_wr && reg_addr == pe_regs_pkg::OFS_TPERIOD ##1 reg_rd && !reg_wr && reg_addr == pe_regs_pkg::OFS_TPERIOD)
      |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_period: assert property (p_period) else $error("period readback wrong");
   // Flag words keep the full 32 bits
   property p_flags;
      (reg_wr && reg_addr[7:2] == 6'h09 ##1 reg_rd && !reg_wr && reg_addr == $past(reg_addr))
      |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_flags: assert property (p_flags) else $error("flag readback wrong");
   // Main scenarios reached
   c_irq: cover property (irq);
   c_hit: cover property (test_hit);
   c_wide: cover property (cu_we && cu_wide);
endmodule

bind pe_data_regs_timer_ustat pe_regs_checker u_chk (.*);

// ==== verification/cu_model.sv ====
/*
 Compute unit stand-in: turns a bench request into a one-cycle write.
 Assumes requests are one-cycle pulses on req_go.
*/
`timescale 1ns/1ns
module cu_model (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic req_go,
   input wire logic [3:0] req_idx,
   input wire logic [39:0] req_data,
   input wire logic req_wide,
   output logic cu_we,
   output logic [3:0] cu_widx,
   output logic [39:0] cu_wdata,
   output logic cu_wide
);
   // Result write one cycle after the request, like a unit finishing
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         {cu_we, cu_widx, cu_wdata, cu_wide} <= '0;
      end else begin
         {cu_we, cu_widx, cu_wdata, cu_wide} <= {req_go, req_idx, req_data, req_wide};
      end
   end
endmodule

// ==== verification/tb.sv ====
/*
 Self-checking bench for the register bank.
 Assumes the checker is bound to the design by its own file.
*/
`timescale 1ns/1ns
module tb;
   logic ref_clk = 1'h0;
   logic rst_b = 1'h0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'h0, reg_rd = 1'h0, float_view_prefix = 1'h0, secondary_element = 1'h0;
   logic [3:0] cu_ridx_a = 4'h0, cu_ridx_b = 4'h0, req_idx = 4'h0;
   logic [1:0] test_sel = 2'h0;
   logic [31:0] test_mask = 32'h0000_0000;
   logic req_go = 1'h0, req_wide = 1'h0;
   logic [39:0] req_data = 40'h00_0000_0000;
   wire logic cu_we, cu_wide, cu_float_mode, cu_sel_element, test_hit, irq;
   wire logic [3:0] cu_widx;
   wire logic [39:0] cu_wdata, cu_rdata_a, cu_rdata_b;
   wire logic [31:0] reg_rdata;
   int err_total = 0, check_count = 0;
   always #5 ref_clk = ~ref_clk;
   pe_data_regs_timer_ustat dut (.*);
   cu_model u_cu (.ref_clk(ref_clk), .rst_b(rst_b), .req_go(req_go), .req_idx(req_idx), .req_data(req_data),
      .req_wide(req_wide), .cu_we(cu_we), .cu_widx(cu_widx), .cu_wdata(cu_wdata), .cu_wide(cu_wide));
   ////////////////////////////////////////
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   // Write strobe stays up so a read may follow with no gap
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'h1;
      reg_rd <= 1'h0;
      reg_addr <= a;
      reg_wdata <= d;
   endtask
   task automatic idle;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
      reg_rd <= 1'h0;
   endtask
   // Data is taken in the single cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'h1;
      reg_wr <= 1'h0;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1 d = reg_rdata;
   endtask
   // Compute write, then both read ports settle on that index
   task automatic cu_put(input logic [3:0] i, input logic [39:0] d, input logic w);
      @(posedge ref_clk);
      {req_go, req_idx, req_data, req_wide, cu_ridx_a, cu_ridx_b} <= {1'h1, i, d, w, i, i};
      @(posedge ref_clk);
      req_go <= 1'h0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   ////////////////////////////////////////
   task automatic t_regs;
      logic [31:0] v;
      wr(pe_regs_pkg::OFS_TPERIOD, 32'h1234_ABCD);
      rd(pe_regs_pkg::OFS_TPERIOD, v);
      check(v, 32'h1234_ABCD);
      for (int i = 0; i < 4; i++) begin
         wr(pe_regs_pkg::OFS_FLAGS_BASE + 8'(i), 32'hA5C3_0F0F ^ 32'(i));
         rd(pe_regs_pkg::OFS_FLAGS_BASE + 8'(i), v);
         check(v, 32'hA5C3_0F0F ^ 32'(i));
      end
      // Unmapped place: write ignored, read gives zero
      wr(8'h30, 32'hFFFF_FFFF);
      rd(8'h30, v);
      check(v, 32'h0000_0000);
   endtask
   task automatic t_data;
      logic [31:0] v;
      cu_put(4'h3, 40'hA5_1234_5678, 1'h1);
      check(cu_rdata_a, 40'hA5_1234_5678);
      rd(8'h03, v);
      check(v, 32'h1234_5678);
      rd(8'h13, v);
      check(v, 32'h0000_00A5);
      // Highest index, narrow load lands shifted up
      cu_put(4'hF, 40'h77_CAFE_F00D, 1'h0);
      check(cu_rdata_b, 40'hCA_FEF0_0D00);
      // Software store seen through the float view
      wr(8'h05, 32'h0000_BEEF);
      wr(8'h15, 32'h0000_007E);
      idle;
      {cu_ridx_a, float_view_prefix, secondary_element} <= {4'h5, 1'h1, 1'h1};
      @(posedge ref_clk);
      #1 check(cu_rdata_a, 40'h7E_0000_BEEF);
      check({cu_float_mode, cu_sel_element}, 2'h3);
   endtask
   task automatic t_flags;
      @(posedge ref_clk);
      test_mask <= 32'h0000_0100;
      test_sel <= 2'h0;
      wr(pe_regs_pkg::OFS_FLAGS_BASE, 32'h0000_0100);
      idle;
      @(posedge ref_clk);
      #1 check(test_hit, 1'h1);
      test_mask <= 32'h0000_0200;
      repeat (2) @(posedge ref_clk);
      #1 check(test_hit, 1'h0);
   endtask
   task automatic t_timer;
      logic [31:0] v, w;
      wr(pe_regs_pkg::OFS_TCOUNT, 32'h0000_0400);
      wr(pe_regs_pkg::OFS_TIMER_CTRL, 32'h0000_0001);
      idle;
      // Two reads exactly ten cycles apart
      rd(pe_regs_pkg::OFS_TCOUNT, v);
      repeat (8) @(posedge ref_clk);
      rd(pe_regs_pkg::OFS_TCOUNT, w);
      check(v - w, 32'h0000_000A);
      wr(pe_regs_pkg::OFS_TPERIOD, 32'h0000_0002);
      wr(pe_regs_pkg::OFS_TCOUNT, 32'h0000_0003);
      idle;
      repeat (20) @(posedge ref_clk);
      #1 check(irq, 1'h0);
      rd(pe_regs_pkg::OFS_IRQ_STATUS, v);
      check(v, 32'h0000_0001);
      wr(pe_regs_pkg::OFS_IRQ_ENABLE, 32'h0000_0001);
      idle;
      repeat (2) @(posedge ref_clk);
      #1 check(irq, 1'h1);
      wr(pe_regs_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
      wr(pe_regs_pkg::OFS_TIMER_CTRL, 32'h0000_0000);
      idle;
      // Let a late expiry land before clearing
      repeat (4) @(posedge ref_clk);
      wr(pe_regs_pkg::OFS_IRQ_CLEAR, 32'h0000_0001);
      rd(pe_regs_pkg::OFS_IRQ_STATUS, v);
      check(v, 32'h0000_0000);
   endtask
   ////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'h1;
      t_regs;
      t_data;
      t_flags;
      t_timer;
      test_done;
   end
   // Whole run is about a hundred cycles
   initial begin
      repeat (3000) @(posedge ref_clk);
      err_total++;
      test_done;
   end
endmodule
